// ---- src/bfc_core.sv ----
`timescale 1ns/1ns
module bfc_core
  import bfc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        cyc_entry,
  input  wire logic        db_open,
  input  wire logic [15:0] db_len,
  input  wire logic [15:0] db_start,
  input  wire logic        ret_restore,
  input  wire logic [15:0] ret_len,
  input  wire logic [15:0] ret_start,
  input  wire logic        ptr_write,
  input  wire logic [15:0] ptr_value,
  input  wire logic        var_access,
  input  wire logic [15:0] var_shift,
  output logic             var_err,
  input  wire logic        op_step,
  input  wire logic        op_branch,
  input  wire logic [15:0] op_target,
  output logic [15:0]      next_op_address,
  output logic [15:0]      data_block_length,
  output logic [15:0]      block_start_pointer,
  input  wire logic        copy_req,
  input  wire logic        copy_word,
  input  wire logic [7:0]  copy_count,
  input  wire logic [15:0] accumulator_one_low,
  input  wire logic [15:0] accumulator_two_low,
  input  wire logic [15:0] accumulator_three_low,
  input  wire logic        ind_req,
  input  wire logic        ind_load,
  input  wire logic [3:0]  ind_reg,
  output logic             busy,
  output logic             copy_done,
  output logic             copy_err,
  output logic             mem_req,
  output logic             mem_we,
  output logic             mem_byte,
  output logic [15:0]      mem_addr,
  output logic [15:0]      mem_wdata,
  input  wire logic [15:0] mem_rdata,
  input  wire logic        mem_ack,
  output logic             ld_valid,
  output logic [3:0]       ld_reg,
  output logic [15:0]      ld_data
);

  typedef struct packed {
    bfc_state_type st;
    logic [15:0]   start_ptr;
    logic [15:0]   blk_len;
    logic [15:0]   next_op;
    logic [15:0]   rd_addr;
    logic [15:0]   wr_addr;
    logic [7:0]    rd_left;
    logic [7:0]    wr_left;
    logic          word_mode;
    logic [3:0]    ind_reg;
    logic          mem_req;
    logic          mem_we;
    logic          mem_byte;
    logic [15:0]   mem_addr;
    logic [15:0]   mem_wdata;
    logic          ld_valid;
    logic [3:0]    ld_reg;
    logic [15:0]   ld_data;
    logic          var_err;
    logic          copy_err;
    logic          copy_done;
  } bfc_core_type;

  bfc_core_type q;
  bfc_core_type d;
  logic         src_byte;
  logic         src_ok;
  logic         dst_byte;
  logic         dst_ok;
  logic         fifo_push;
  logic         fifo_pop;
  logic [15:0]  fifo_wdata;
  logic         store_ok;
  logic [15:0]  store_val;

  bfc_fifo_if #(.W(DATA_W)) fq ();

  bfc_fifo #(
    .W     (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .fi       (fq.fifo)
  );

  bfc_mem_sel u_src_sel (
    .addr      (accumulator_two_low),
    .byte_area (src_byte),
    .copy_ok   (src_ok)
  );

  bfc_mem_sel u_dst_sel (
    .addr      (accumulator_one_low),
    .byte_area (dst_byte),
    .copy_ok   (dst_ok)
  );

  assign fq.in_valid  = fifo_push;
  assign fq.in_data   = fifo_wdata;
  assign fq.out_ready = fifo_pop;

  // Store source for registers 1, 3, 6, 8 and 10; other register numbers refuse a store
  always_comb
  begin
    store_ok  = 1'b1;
    store_val = '0;
    case (ind_reg)
      REG_ACC1_LOW:  store_val = accumulator_one_low;
      REG_ACC2_LOW:  store_val = accumulator_two_low;
      REG_START_PTR: store_val = q.start_ptr;
      REG_BLK_LEN:   store_val = q.blk_len;
      REG_ACC3_LOW:  store_val = accumulator_three_low;
      default:       store_ok  = 1'b0;
    endcase
  end

  always_comb
  begin
    d           = q;
    d.var_err   = 1'b0;
    d.copy_err  = 1'b0;
    d.copy_done = 1'b0;
    d.ld_valid  = 1'b0;
    fifo_push   = 1'b0;
    fifo_pop    = 1'b0;
    fifo_wdata  = q.word_mode ? mem_rdata : {HIGH_ZERO, mem_rdata[7:0]};
    case (q.st)
      ST_IDLE:
      begin
        if (copy_req)
        begin
          if (!src_ok || !dst_ok)
            d.copy_err = 1'b1;
          else if (copy_count == '0)
            d.copy_done = 1'b1;
          else
          begin
            d.rd_addr   = accumulator_two_low;
            d.wr_addr   = accumulator_one_low;
            d.rd_left   = copy_count;
            d.wr_left   = copy_count;
            d.word_mode = copy_word;
            d.st        = ST_CP;
          end
        end
        else if (ind_req && reg_exists(ind_reg) && (ind_load || store_ok))
        begin
          d.mem_req  = 1'b1;
          d.mem_addr = accumulator_one_low;
          d.mem_byte = dst_byte;
          d.ind_reg  = ind_reg;
          d.mem_we   = !ind_load;
          d.mem_wdata = dst_byte ? {HIGH_ZERO, store_val[7:0]} : store_val;
          d.st       = ind_load ? ST_LD : ST_ST;
        end
      end
      ST_CP:
      begin
        // Reads go first while any remain and the buffer has room; a write goes when it is full or reads are done
        if ((q.rd_left != '0) && fq.in_ready)
        begin
          d.mem_req  = 1'b1;
          d.mem_we   = 1'b0;
          d.mem_addr = q.rd_addr;
          d.mem_byte = !q.word_mode;
          d.st       = ST_CP_RD;
        end
        else if (fq.out_valid)
        begin
          fifo_pop    = 1'b1;
          d.mem_req   = 1'b1;
          d.mem_we    = 1'b1;
          d.mem_addr  = q.wr_addr;
          d.mem_byte  = !q.word_mode;
          d.mem_wdata = fq.out_data;
          d.st        = ST_CP_WR;
        end
      end
      ST_CP_RD:
      begin
        if (mem_ack)
        begin
          fifo_push = 1'b1;
          d.mem_req = 1'b0;
          d.rd_addr = q.rd_addr - INC_ONE;
          d.rd_left = q.rd_left - 8'h01;
          d.st      = ST_CP;
        end
      end
      ST_CP_WR:
      begin
        if (mem_ack)
        begin
          d.mem_req = 1'b0;
          d.wr_addr = q.wr_addr - INC_ONE;
          d.wr_left = q.wr_left - 8'h01;
          if (q.wr_left == 8'h01)
          begin
            d.copy_done = 1'b1;
            d.st        = ST_IDLE;
          end
          else
            d.st = ST_CP;
        end
      end
      ST_LD:
      begin
        if (mem_ack)
        begin
          d.mem_req  = 1'b0;
          d.ld_valid = 1'b1;
          d.ld_reg   = q.ind_reg;
          d.ld_data  = q.mem_byte ? {BYTE_FILL, mem_rdata[7:0]} : mem_rdata;
          if (q.ind_reg == REG_START_PTR)
            d.start_ptr = d.ld_data;
          if (q.ind_reg == REG_BLK_LEN)
            d.blk_len = d.ld_data;
          d.st = ST_IDLE;
        end
      end
      ST_ST:
      begin
        if (mem_ack)
        begin
          d.mem_req = 1'b0;
          d.st      = ST_IDLE;
        end
      end
      default:
        d.st = ST_IDLE;
    endcase

    // Step counter
    if (op_branch)
      d.next_op = op_target;
    else if (op_step)
      d.next_op = q.next_op + INC_ONE;

    // Block pointer and length; jumps and inserted levels need no action
    if (ptr_write)
      d.start_ptr = ptr_value;
    if (var_access)
    begin
      if (var_shift < q.blk_len)
      begin
        d.start_ptr = q.start_ptr + var_shift;
        d.blk_len   = q.blk_len - var_shift;
      end
      else
        d.var_err = 1'b1;
    end
    if (ret_restore)
    begin
      d.blk_len   = ret_len;
      d.start_ptr = ret_start;
    end
    if (db_open)
    begin
      d.blk_len   = db_len;
      d.start_ptr = db_start;
    end
    if (cyc_entry)
    begin
      d.blk_len   = LEN_RST;
      d.start_ptr = PTR_RST;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      q <= '0;
    else
      q <= d;
  end

  assign busy                = (q.st != ST_IDLE);
  assign var_err             = q.var_err;
  assign copy_done           = q.copy_done;
  assign copy_err            = q.copy_err;
  assign next_op_address     = q.next_op;
  assign data_block_length   = q.blk_len;
  assign block_start_pointer = q.start_ptr;
  assign mem_req             = q.mem_req;
  assign mem_we              = q.mem_we;
  assign mem_byte            = q.mem_byte;
  assign mem_addr            = q.mem_addr;
  assign mem_wdata           = q.mem_wdata;
  assign ld_valid            = q.ld_valid;
  assign ld_reg              = q.ld_reg;
  assign ld_data             = q.ld_data;

  // Length changes only on its own events
  logic len_evt;
  assign len_evt = cyc_entry || db_open || ret_restore || var_access
                   || ((q.st == ST_LD) && mem_ack && (q.ind_reg == REG_BLK_LEN));

  cyc_clear_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    cyc_entry |=> (data_block_length == LEN_RST))
    else $error("length not cleared on cyclic entry");

  db_open_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (db_open && !cyc_entry) |=> (data_block_length == $past(db_len)))
    else $error("length not loaded on block open");

  len_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !len_evt |=> $stable(data_block_length))
    else $error("length changed without cause");

  ptr_write_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (ptr_write && !len_evt) |=> ($stable(data_block_length)
      && (block_start_pointer == $past(ptr_value))))
    else $error("direct pointer write disturbed length");

  var_shift_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (var_access && (var_shift < data_block_length) && !cyc_entry && !db_open && !ret_restore)
    |=> ((block_start_pointer == $past(block_start_pointer) + $past(var_shift))
      && (data_block_length == $past(data_block_length) - $past(var_shift)) && !var_err))
    else $error("variable access shift wrong");

  next_op_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (op_step && !op_branch) |=> (next_op_address == $past(next_op_address) + INC_ONE))
    else $error("step counter did not advance");

  copy_src_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!busy && copy_req && src_ok && dst_ok && (copy_count != '0))
    |=> ##1 (mem_req && !mem_we && (mem_addr == $past(accumulator_two_low, 2))))
    else $error("copy did not start at source end address");

  zero_count_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!busy && copy_req && src_ok && dst_ok && (copy_count == '0))
    |=> (copy_done && !busy && !mem_req))
    else $error("zero count copy moved data");

  page_reject_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!busy && copy_req && in_range(accumulator_one_low, PAGE_LO, PAGE_HI))
    |=> (copy_err && !busy))
    else $error("copy into page area not refused");

  store_acc3_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!busy && !copy_req && ind_req && !ind_load && (ind_reg == REG_ACC3_LOW) && !dst_byte)
    |=> (mem_req && mem_we && (mem_addr == $past(accumulator_one_low))
      && (mem_wdata == $past(accumulator_three_low))))
    else $error("indirect store of register 10 wrong");

  byte_fill_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ((q.st == ST_LD) && mem_ack && mem_byte)
    |=> (ld_valid && (ld_data == {BYTE_FILL, $past(mem_rdata[7:0])})))
    else $error("byte area load high byte not filled");

  copy_len_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ((q.st == ST_CP_WR) && mem_ack && (q.wr_left == 8'h01)) |=> (copy_done && !busy))
    else $error("copy did not end after last element");

endmodule : bfc_core

// ---- src/bfc_pkg.sv ----
package bfc_pkg;

  localparam logic [15:0] LEN_RST     = 16'h0000;
  localparam logic [15:0] PTR_RST     = 16'h0000;
  localparam logic [15:0] NEXT_OP_RST = 16'h0000;
  localparam logic [15:0] INC_ONE     = 16'h0001;
  localparam logic [7:0]  BYTE_FILL   = 8'hFF;
  localparam logic [7:0]  HIGH_ZERO   = 8'h00;
  localparam int          FIFO_DEPTH  = 4;
  localparam int          DATA_W      = 16;

  // Register numbers for indirect access
  localparam logic [3:0] REG_ACC1_LOW  = 4'h1;
  localparam logic [3:0] REG_ACC2_LOW  = 4'h3;
  localparam logic [3:0] REG_START_PTR = 4'h6;
  localparam logic [3:0] REG_BLK_LEN   = 4'h8;
  localparam logic [3:0] REG_ACC3_LOW  = 4'hA;
  localparam logic [3:0] REG_NEXT_OP   = 4'hF;

  // Address areas
  localparam logic [15:0] BYTE_A_LO = 16'hE400;
  localparam logic [15:0] BYTE_A_HI = 16'hE7FF;
  localparam logic [15:0] BYTE_B_LO = 16'hEE00;
  localparam logic [15:0] GLOB_A_LO = 16'hF000;
  localparam logic [15:0] GLOB_A_HI = 16'hF3FF;
  localparam logic [15:0] PAGE_LO   = 16'hF400;
  localparam logic [15:0] PAGE_HI   = 16'hFBFF;
  localparam logic [15:0] GLOB_B_LO = 16'hFC00;
  localparam logic [15:0] GLOB_B_HI = 16'hFFFF;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CP,
    ST_CP_RD,
    ST_CP_WR,
    ST_LD,
    ST_ST
  } bfc_state_type;

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // Register numbers that exist for indirect load and store
  function automatic logic reg_exists(input logic [3:0] n);
    case (n)
      4'h4, 4'h7, 4'hD, 4'hE, 4'hF: reg_exists = 1'b0;
      default:                      reg_exists = 1'b1;
    endcase
  endfunction : reg_exists

endpackage : bfc_pkg

// ---- src/bfc_fifo_if.sv ----
`timescale 1ns/1ns
interface bfc_fifo_if #(parameter int W = 16);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;

  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : bfc_fifo_if

// ---- src/bfc_fifo.sv ----
`timescale 1ns/1ns
module bfc_fifo
  import bfc_pkg::*;
#(
  parameter int W     = 16,
  parameter int DEPTH = 4
)(
  input wire logic core_clk,
  input wire logic rst_b,
  bfc_fifo_if.fifo fi
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [CW-1:0]           cnt;
  } bfc_fifo_state_type;

  bfc_fifo_state_type q;
  bfc_fifo_state_type d;
  logic               push;
  logic               pop;

  assign fi.in_ready  = (q.cnt != CW'(DEPTH));
  assign fi.out_valid = (q.cnt != '0);
  assign fi.out_data  = q.mem[q.rp];

  always_comb
  begin
    d    = q;
    push = fi.in_valid && fi.in_ready;
    pop  = fi.out_valid && fi.out_ready;
    if (push)
    begin
      d.mem[q.wp] = fi.in_data;
      d.wp        = (q.wp == PW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
    end
    if (pop)
      d.rp = (q.rp == PW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
    if (push && !pop)
      d.cnt = q.cnt + 1'b1;
    else if (pop && !push)
      d.cnt = q.cnt - 1'b1;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      q <= '0;
    else
      q <= d;
  end
endmodule : bfc_fifo

// ---- src/bfc_mem_sel.sv ----
`timescale 1ns/1ns
module bfc_mem_sel
  import bfc_pkg::*;
(
  input  wire logic [15:0] addr,
  output logic             byte_area,
  output logic             copy_ok
);
  // Byte organised areas take one byte per access
  assign byte_area = in_range(addr, BYTE_A_LO, BYTE_A_HI) || (addr >= BYTE_B_LO);
  // Copies reach local memory and both byte wide global ranges, not the page area
  assign copy_ok   = !in_range(addr, PAGE_LO, PAGE_HI)
                     || in_range(addr, GLOB_A_LO, GLOB_A_HI)
                     || in_range(addr, GLOB_B_LO, GLOB_B_HI);
endmodule : bfc_mem_sel

// ---- test/bfc_mem_model.sv ----
`timescale 1ns/1ns
module bfc_mem_model
  import bfc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic [3:0]  ack_wait,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic        mem_byte,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic [15:0]      mem_rdata,
  output logic             mem_ack
);
  logic [15:0] mem [0:65535];
  logic [3:0]  wait_q;
  logic        served_q;

  // One ack per request after ack_wait cycles; read data valid only in the ack cycle
  // Plain always: the bench preloads this array directly
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mem_ack   <= 1'b0;
      mem_rdata <= 16'h0000;
      wait_q    <= 4'h0;
      served_q  <= 1'b0;
    end
    else
    begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (!mem_req)
      begin
        served_q <= 1'b0;
        wait_q   <= 4'h0;
      end
      else if (!served_q && wait_q >= ack_wait)
      begin
        mem_ack   <= 1'b1;
        served_q  <= 1'b1;
        mem_rdata <= mem[mem_addr];
        if (mem_we)
          mem[mem_addr] <= mem_byte ? {8'h00, mem_wdata[7:0]} : mem_wdata;
      end
      else if (!served_q)
        wait_q <= wait_q + 4'h1;
    end
  end
endmodule : bfc_mem_model

// ---- test/block_register_and_field_copy_test.sv ----
`timescale 1ns/1ns
module block_register_and_field_copy_test
  import bfc_pkg::*;
;
  logic        core_clk, rst_b, cyc_entry, db_open, ret_restore, ptr_write, var_access;
  logic        op_step, op_branch, copy_req, copy_word, ind_req, ind_load, var_err, busy;
  logic        copy_done, copy_err, mem_req, mem_we, mem_byte, mem_ack, ld_valid, e;
  logic [15:0] db_len, db_start, ret_len, ret_start, ptr_value, var_shift, op_target;
  logic [15:0] next_op_address, data_block_length, block_start_pointer, ld_data;
  logic [15:0] accumulator_one_low, accumulator_two_low, accumulator_three_low;
  logic [15:0] mem_addr, mem_wdata, mem_rdata;
  logic [7:0]  copy_count;
  logic [3:0]  ind_reg, ld_reg, ack_wait;
  int          err_total, samples_checked;

  bfc_core u_dut (.core_clk, .rst_b, .cyc_entry, .db_open, .db_len, .db_start, .ret_restore,
    .ret_len, .ret_start, .ptr_write, .ptr_value, .var_access, .var_shift, .var_err,
    .op_step, .op_branch, .op_target, .next_op_address, .data_block_length,
    .block_start_pointer, .copy_req, .copy_word, .copy_count, .accumulator_one_low,
    .accumulator_two_low, .accumulator_three_low, .ind_req, .ind_load, .ind_reg, .busy,
    .copy_done, .copy_err, .mem_req, .mem_we, .mem_byte, .mem_addr, .mem_wdata, .mem_rdata,
    .mem_ack, .ld_valid, .ld_reg, .ld_data);

  bfc_mem_model u_mem (.core_clk, .rst_b, .ack_wait, .mem_req, .mem_we, .mem_byte,
    .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);

  always #10 core_clk = ~core_clk;

  task automatic tick();
    @(posedge core_clk);
    #2;
  endtask : tick

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : chk

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // Length and start pointer through open, jump, direct write, shift, return, entry
  task automatic t_length();
    db_len = 16'h0008; db_start = 16'h151B; db_open = 1'b1; tick(); db_open = 1'b0;
    chk(data_block_length, 16'h0008);
    op_target = 16'h0400; op_branch = 1'b1; tick(); op_branch = 1'b0;
    chk(data_block_length, 16'h0008);
    ptr_value = 16'h1600; ptr_write = 1'b1; tick(); ptr_write = 1'b0;
    chk(block_start_pointer, 16'h1600);
    chk(data_block_length, 16'h0008);
    var_shift = 16'h0007; var_access = 1'b1; tick(); var_access = 1'b0;
    chk(data_block_length, 16'h0001);
    chk(block_start_pointer, 16'h1607);
    var_shift = 16'h0001; var_access = 1'b1; tick(); var_access = 1'b0;
    e = var_err; tick(); e = e | var_err;
    chk({15'h0000, e}, 16'h0001);
    chk(data_block_length, 16'h0001);
    ret_len = 16'h0020; ret_start = 16'h2000; ret_restore = 1'b1; tick(); ret_restore = 1'b0;
    chk(data_block_length, 16'h0020);
    db_len = 16'h00FF; db_open = 1'b1; tick(); db_open = 1'b0;
    chk(data_block_length, 16'h00FF);
    db_open = 1'b1; cyc_entry = 1'b1; tick(); db_open = 1'b0; cyc_entry = 1'b0;
    chk(data_block_length, 16'h0000);
  endtask : t_length

  // Step counter: branch, steps, branch winning over a step
  task automatic t_step();
    op_target = 16'h1234; op_branch = 1'b1; tick(); op_branch = 1'b0;
    chk(next_op_address, 16'h1234);
    op_step = 1'b1; tick(); tick(); op_step = 1'b0;
    chk(next_op_address, 16'h1236);
    op_target = 16'h0FFF; op_step = 1'b1; op_branch = 1'b1; tick();
    op_step = 1'b0; op_branch = 1'b0;
    chk(next_op_address, 16'h0FFF);
  endtask : t_step

  // Field copy; areas are disjoint and inside one permitted area
  task automatic t_copy(input logic wd, input logic [7:0] cnt, input logic [15:0] src,
                        input logic [15:0] dst, input logic [3:0] wt);
    int          n;
    logic [15:0] p;
    ack_wait = wt;
    for (n = 0; n <= cnt; n++)
    begin
      u_mem.mem[16'(src - n)] = 16'h5A00 + 16'(n);
      u_mem.mem[16'(dst - n)] = 16'hDEAD;
    end
    accumulator_two_low = src; accumulator_one_low = dst;
    copy_count = cnt; copy_word = wd; copy_req = 1'b1; tick(); copy_req = 1'b0;
    n = 0;
    while (copy_done !== 1'b1 && n < 4000)
    begin
      tick();
      n++;
    end
    if (n >= 4000)
      err_total++;
    for (n = 0; n < cnt; n++)
    begin
      p = 16'h5A00 + 16'(n);
      chk(u_mem.mem[16'(dst - n)], wd ? p : {8'h00, p[7:0]});
    end
    chk(u_mem.mem[16'(dst - cnt)], 16'hDEAD);
  endtask : t_copy

  // Indirect access; waits for the load result or the end of busy
  task automatic t_ind(input logic ld, input logic [3:0] rn, input logic [15:0] a,
                       input logic [15:0] d);
    int n;
    accumulator_one_low = a; accumulator_three_low = d;
    ind_load = ld; ind_reg = rn; ind_req = 1'b1; tick(); ind_req = 1'b0;
    n = 0;
    while (n < 50 && (ld ? ld_valid !== 1'b1 : busy === 1'b1))
    begin
      tick();
      n++;
    end
    if (n >= 50)
      err_total++;
  endtask : t_ind

  task automatic t_indirect();
    ack_wait = 4'h1;
    t_ind(1'b0, 4'hA, 16'h0300, 16'hBEEF);
    chk(u_mem.mem[16'h0300], 16'hBEEF);
    t_ind(1'b0, 4'hA, 16'hE400, 16'h1299);
    chk(u_mem.mem[16'hE400], 16'h0099);
    t_ind(1'b0, 4'hF, 16'h0300, 16'h1111);
    chk(u_mem.mem[16'h0300], 16'hBEEF);
    u_mem.mem[16'hE401] = 16'h1234;
    t_ind(1'b1, 4'h3, 16'hE401, 16'h0000);
    chk(ld_data, 16'hFF34);
    chk({12'h000, ld_reg}, 16'h0003);
  endtask : t_indirect

  // Copy whose destination end lies in the page area is refused
  task automatic t_refuse();
    u_mem.mem[16'hFA00] = 16'hDEAD;
    accumulator_two_low = 16'h0105;
    accumulator_one_low = 16'hFA00;
    copy_count = 8'h03;
    copy_word = 1'b1;
    copy_req = 1'b1;
    tick();
    copy_req = 1'b0;
    chk({13'h0000, copy_err, copy_done, busy}, 16'h0004);
    tick();
    tick();
    tick();
    chk({15'h0000, mem_req}, 16'h0000);
    chk(u_mem.mem[16'hFA00], 16'hDEAD);
  endtask : t_refuse

  initial
  begin
    core_clk = 1'b0; rst_b = 1'b0; cyc_entry = 1'b0; db_open = 1'b0; ret_restore = 1'b0;
    ptr_write = 1'b0; var_access = 1'b0; op_step = 1'b0; op_branch = 1'b0;
    copy_req = 1'b0; copy_word = 1'b0; ind_req = 1'b0; ind_load = 1'b0;
    db_len = 16'h0000; db_start = 16'h0000; ret_len = 16'h0000; ret_start = 16'h0000;
    ptr_value = 16'h0000; var_shift = 16'h0000; op_target = 16'h0000;
    accumulator_one_low = 16'h0000; accumulator_two_low = 16'h0000;
    accumulator_three_low = 16'h0000; copy_count = 8'h00; ind_reg = 4'h0; ack_wait = 4'h0;
    err_total = 0; samples_checked = 0;
    repeat (4) @(posedge core_clk);
    #2;
    rst_b = 1'b1;
    chk(data_block_length, 16'h0000);
    t_length();
    t_step();
    t_copy(1'b1, 8'h06, 16'h0105, 16'h0205, 4'h2);
    t_copy(1'b0, 8'h03, 16'hF3F2, 16'hFC02, 4'h0);
    t_copy(1'b1, 8'hFF, 16'h10FE, 16'h30FE, 4'h0);
    t_copy(1'b1, 8'h00, 16'h0400, 16'h0500, 4'h0);
    t_refuse();
    t_indirect();
    give_verdict();
  end

  // Watchdog well beyond the expected few thousand cycles
  initial
  begin
    #400000;
    err_total++;
    give_verdict();
  end
endmodule : block_register_and_field_copy_test
